// file: rtl/ssh_core.sv
// serial shift channel and port a handshake with an apb register slave
// ****************************************
// What this block does
// - port b lines two, three carry clock, data
// - control bits four, five enable, pick clock
// - internal clock shifts at half rate
// - control bit six picks data direction
// - one bit per clock, msb first
// - external mode sets flag five after eight
// - flag with enable sets pending request
// - handshake mode uses strobe and ack lines
// - ack low on port a access
// - ack high on strobe falling edge
// - strobe fall sets flag, port access clears
// - flags set by events, clear by one
// - serial data access clears shift flag
// ****************************************
//
// Chosen here: the APB register port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
`include "ssh_params.svh"
module ssh_core (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        port_b_line_two_i,
  input  wire logic        port_b_line_three_i,
  output ssh_pkg::ssh_ser_out_t ser_out,
  input  wire logic        handshake_strobe_in,
  output logic             handshake_ack_out,
  input  wire logic [7:0]  parallel_port_a_i,
  output logic      [7:0]  parallel_port_a_o,
  output logic             irq_pending
);
  // ****************************************
  // apb decode
  // ****************************************
  logic acc;                              // access phase
  logic wr;                               // write strobe
  logic rd;                               // read strobe
  logic hit;                              // mapped address
  assign acc     = psel & penable;
  assign wr      = acc & pwrite;
  assign rd      = acc & ~pwrite;
  assign pready  = 1'b1;                  // zero wait states
  assign hit     = (paddr == `SSH_OFF_PORTA) | (paddr == `SSH_OFF_IFR) | (paddr == `SSH_OFF_IER) |
                   (paddr == `SSH_OFF_ACR) | (paddr == `SSH_OFF_PCR) | (paddr == `SSH_OFF_SDR);
  assign pslverr = acc & ~hit;            // unmapped answers error
  logic pa_acc;                           // port a touched
  logic sd_acc;                           // serial data touched
  assign pa_acc = acc & (paddr == `SSH_OFF_PORTA);
  assign sd_acc = acc & (paddr == `SSH_OFF_SDR);
  // ****************************************
  // input synchronisers
  // ****************************************
  logic [2:0] s_clk_q;                    // [0] first stage only feeds [1]
  logic [2:0] s_dat_q;
  logic [2:0] s_stb_q;
  logic [7:0] pa_m;                       // port a first stage
  logic [7:0] pa_s;                       // port a second stage
  logic [2:0] next_s_clk_q;
  logic [2:0] next_s_dat_q;
  logic [2:0] next_s_stb_q;
  always_comb begin
    next_s_clk_q = {s_clk_q[1:0], port_b_line_two_i};
    next_s_dat_q = {s_dat_q[1:0], port_b_line_three_i};
    next_s_stb_q = {s_stb_q[1:0], handshake_strobe_in};
  end
  always_ff @(posedge clk) begin
    s_clk_q <= next_s_clk_q;
    s_dat_q <= next_s_dat_q;
    s_stb_q <= next_s_stb_q;
    pa_m    <= parallel_port_a_i;
    pa_s    <= pa_m;
  end
  logic ext_rise;                         // external clock rising edge
  logic ext_fall;                         // external clock falling edge
  logic stb_fall;                         // strobe falling edge
  assign ext_rise = s_clk_q[1] & ~s_clk_q[2];
  assign ext_fall = ~s_clk_q[1] & s_clk_q[2];
  assign stb_fall = ~s_stb_q[1] & s_stb_q[2];
  // ****************************************
  // registers and serial engine
  // ****************************************
  logic [7:0] auxiliary_control_reg;                        // auxiliary_control_reg
  logic [7:0] peripheral_control_reg;                        // peripheral_control_reg
  logic [7:0] ier;                        // interrupt enables
  logic [7:0] ifr;                        // interrupt flags
  logic [7:0] pa_out;                     // port a output latch
  logic [7:0] sdr;                        // serial shift register
  logic [3:0] cnt;                        // shifts remaining
  logic       sclk;                       // internal clock level
  logic       sdo;                        // data out level
  logic       ack;                        // handshake ack level
  ssh_pkg::ssh_state_t st;
  logic [7:0] next_acr, next_pcr, next_ier, next_ifr, next_pa_out, next_sdr;
  logic [3:0] next_cnt;
  logic       next_sclk, next_sdo, next_ack;
  ssh_pkg::ssh_state_t next_st;
  logic ser_en, ext_mode, dir_out, hs_en;
  logic set_ser;                          // eighth shift done in external mode
  assign ser_en   = auxiliary_control_reg[`SSH_ACR_SER_EN];
  assign ext_mode = auxiliary_control_reg[`SSH_ACR_EXT_CLK];
  assign dir_out  = auxiliary_control_reg[`SSH_ACR_DIR_OUT];
  assign hs_en    = peripheral_control_reg[`SSH_PCR_HS_EN];
  // next state of registers, shifter and flags
  always_comb begin
    next_acr    = auxiliary_control_reg;
    next_pcr    = peripheral_control_reg;
    next_ier    = ier;
    next_pa_out = pa_out;
    next_sdr    = sdr;
    next_cnt    = cnt;
    next_sclk   = sclk;
    next_sdo    = sdo;
    next_ack    = ack;
    next_st     = st;
    next_ifr    = ifr;
    set_ser     = 1'b0;
    if (wr) begin
      unique case (paddr)
        `SSH_OFF_ACR:   next_acr    = pwdata[7:0];
        `SSH_OFF_PCR:   next_pcr    = pwdata[7:0];
        `SSH_OFF_IER:   next_ier    = pwdata[7:0];
        `SSH_OFF_PORTA: next_pa_out = pwdata[7:0];
        `SSH_OFF_IFR:   next_ifr    = ifr & ~pwdata[7:0];
        default: ;
      endcase
    end
    // serial engine: internal mode toggles clock every cycle, a full period is two cycles
    unique case (st)
      ssh_pkg::SSH_IDLE: begin
        next_sclk = 1'b1;
        if (wr && (paddr == `SSH_OFF_SDR) && ser_en) begin
          next_sdr = pwdata[7:0];
          next_cnt = `SSH_SHIFTS;
          next_sdo = pwdata[7];
          next_st  = ssh_pkg::SSH_LOW;
        end
      end
      ssh_pkg::SSH_LOW: begin                   // wait for rising edge, sample in
        if (!ser_en) begin
          next_st = ssh_pkg::SSH_IDLE;
        end else if (!ext_mode) begin
          next_sclk = 1'b1;
          next_st   = ssh_pkg::SSH_HIGH;
          next_sdr  = {sdr[6:0], dir_out ? sdr[7] : s_dat_q[2]};
          next_cnt  = cnt - 4'h1;
        end else if (ext_rise) begin
          next_st  = ssh_pkg::SSH_HIGH;
          next_sdr = {sdr[6:0], dir_out ? sdr[7] : s_dat_q[2]};
          next_cnt = cnt - 4'h1;
        end
      end
      ssh_pkg::SSH_HIGH: begin                  // present next bit on falling edge
        if (!ser_en) begin
          next_st = ssh_pkg::SSH_IDLE;
        end else if (cnt == 4'h0) begin
          next_st = ssh_pkg::SSH_IDLE;
          set_ser = ext_mode;
        end else if (!ext_mode || ext_fall) begin
          next_sclk = 1'b0;
          next_sdo  = sdr[7];
          next_st   = ssh_pkg::SSH_LOW;
        end
      end
      default: next_st = ssh_pkg::SSH_IDLE;
    endcase
    if (st == ssh_pkg::SSH_IDLE && wr && paddr == `SSH_OFF_SDR && ser_en && !ext_mode) begin
      next_sclk = 1'b0;                         // first internal low half
    end
    // handshake ack; strobe edge wins over an access in the same cycle
    if (hs_en && pa_acc) next_ack = 1'b0;
    if (stb_fall) next_ack = 1'b1;
    if (pa_acc) next_ifr[`SSH_FLG_HS] = 1'b0;
    if (sd_acc) next_ifr[`SSH_FLG_SER] = 1'b0;
    if (stb_fall) next_ifr[`SSH_FLG_HS] = 1'b1;
    if (set_ser) next_ifr[`SSH_FLG_SER] = 1'b1;
  end
  // register stage
  always_ff @(posedge clk) begin
    if (rst) begin
      auxiliary_control_reg    <= `SSH_RST_BYTE;
      peripheral_control_reg    <= `SSH_RST_BYTE;
      ier    <= `SSH_RST_BYTE;
      ifr    <= `SSH_RST_BYTE;
      pa_out <= `SSH_RST_BYTE;
      sdr    <= `SSH_RST_BYTE;
      cnt    <= 4'h0;
      sclk   <= 1'b1;
      sdo    <= 1'b0;
      ack    <= 1'b1;
      st     <= ssh_pkg::SSH_IDLE;
    end else begin
      auxiliary_control_reg    <= next_acr;
      peripheral_control_reg    <= next_pcr;
      ier    <= next_ier;
      ifr    <= next_ifr;
      pa_out <= next_pa_out;
      sdr    <= next_sdr;
      cnt    <= next_cnt;
      sclk   <= next_sclk;
      sdo    <= next_sdo;
      ack    <= next_ack;
      st     <= next_st;
    end
  end
  // ****************************************
  // outputs and read mux
  // ****************************************
  logic       pend;
  assign pend = |(ifr & ier);
  assign irq_pending = pend;
  always_comb begin
    ser_out.sclk_o  = sclk;
    ser_out.sclk_oe = ser_en & ~ext_mode;
    ser_out.sdio_o  = sdo;
    ser_out.sdio_oe = ser_en & dir_out;
  end
  assign handshake_ack_out = ack;
  assign parallel_port_a_o = pa_out;
  // read data, combinational on the access cycle
  always_comb begin
    prdata = 32'h0000_0000;
    if (rd) begin
      unique case (paddr)
        `SSH_OFF_PORTA: prdata[7:0] = pa_s;
        `SSH_OFF_IFR:   prdata[7:0] = {pend, ifr[6:0]};
        `SSH_OFF_IER:   prdata[7:0] = ier;
        `SSH_OFF_ACR:   prdata[7:0] = auxiliary_control_reg;
        `SSH_OFF_PCR:   prdata[7:0] = peripheral_control_reg;
        `SSH_OFF_SDR:   prdata[7:0] = sdr;
        default: ;
      endcase
    end
  end
  // ****************************************
  // assertions
  // ****************************************
  property p_ack_low;
    @(posedge clk) disable iff (rst) (hs_en && pa_acc && !stb_fall) |=> !handshake_ack_out;
  endproperty
  a_ack_low: assert property (p_ack_low) else $error("ack not low after port access");
  property p_ack_high;
    @(posedge clk) disable iff (rst) stb_fall |=> handshake_ack_out;
  endproperty
  a_ack_high: assert property (p_ack_high) else $error("ack not high after strobe fall");
  property p_hs_flag;
    @(posedge clk) disable iff (rst) stb_fall |=> ifr[`SSH_FLG_HS];
  endproperty
  a_hs_flag: assert property (p_hs_flag) else $error("handshake flag not set");
  property p_hs_clr;
    @(posedge clk) disable iff (rst) (pa_acc && !stb_fall) |=> !ifr[`SSH_FLG_HS];
  endproperty
  a_hs_clr: assert property (p_hs_clr) else $error("handshake flag not cleared");
  property p_pend;
    @(posedge clk) disable iff (rst) irq_pending == |(ifr & ier);
  endproperty
  a_pend: assert property (p_pend) else $error("pending flag mismatch");
  property p_int_rate;
    @(posedge clk) disable iff (rst) (st == ssh_pkg::SSH_LOW && ser_en && !ext_mode) |=> sclk ##1 (!sclk || st == ssh_pkg::SSH_IDLE);
  endproperty
  a_int_rate: assert property (p_int_rate) else $error("internal clock not half rate");
  property p_ser_flag;
    @(posedge clk) disable iff (rst) (set_ser && !sd_acc) |=> ifr[`SSH_FLG_SER];
  endproperty
  a_ser_flag: assert property (p_ser_flag) else $error("shift flag not set");
  property p_no_int_flag;
    @(posedge clk) disable iff (rst) (!ext_mode && !ifr[`SSH_FLG_SER] && !(wr && paddr == `SSH_OFF_ACR)) |=> !ifr[`SSH_FLG_SER];
  endproperty
  a_no_int_flag: assert property (p_no_int_flag) else $error("shift flag set in internal mode");
  property p_ser_clr;
    @(posedge clk) disable iff (rst) (sd_acc && !set_ser) |=> !ifr[`SSH_FLG_SER];
  endproperty
  a_ser_clr: assert property (p_ser_clr) else $error("shift flag not cleared");
  property p_msb;
    @(posedge clk) disable iff (rst) (st == ssh_pkg::SSH_HIGH && next_st == ssh_pkg::SSH_LOW) |=> sdo == $past(sdr[7]);
  endproperty
  a_msb: assert property (p_msb) else $error("data out not msb");
endmodule
`default_nettype wire

// file: rtl/ssh_params.svh
// offsets, field positions, reset values and the shift count for the shift and handshake block
`ifndef SSH_PARAMS_SVH
`define SSH_PARAMS_SVH
// register byte addresses
`define SSH_OFF_PORTA   12'h000
`define SSH_OFF_IFR     12'h004
`define SSH_OFF_IER     12'h008
`define SSH_OFF_ACR     12'h00C
`define SSH_OFF_PCR     12'h010
`define SSH_OFF_SDR     12'h014
// auxiliary control field positions
`define SSH_ACR_SER_EN  4
`define SSH_ACR_EXT_CLK 5
`define SSH_ACR_DIR_OUT 6
// peripheral control field position
`define SSH_PCR_HS_EN   0
// flag positions
`define SSH_FLG_HS      4
`define SSH_FLG_SER     5
// reset values
`define SSH_RST_BYTE    8'h00
// number of shifts in one transfer
`define SSH_SHIFTS      4'h8
`endif

// file: rtl/ssh_pkg.sv
// types for the shift and handshake block
package ssh_pkg;
  typedef enum logic [1:0] {SSH_IDLE, SSH_LOW, SSH_HIGH} ssh_state_t;
  // serial pin group
  typedef struct packed {
    logic sclk_o;
    logic sclk_oe;
    logic sdio_o;
    logic sdio_oe;
  } ssh_ser_out_t;
endpackage

// file: verif/serial_shift_and_port_handshake_test.sv
// self-checking bench of the shift and handshake block
`timescale 1ns/1ns
`default_nettype none
`include "ssh_params.svh"
module serial_shift_and_port_handshake_test;
  // ****************************************
  // signals
  // ****************************************
  logic                  clk, rst, psel, penable, pwrite, pready, pslverr, irq_pending, ack;
  logic [11:0]           paddr;
  logic [31:0]           pwdata, prdata, r;
  logic [7:0]            pa_i, pa_o, seed, b;
  ssh_pkg::ssh_ser_out_t ser_out;
  logic                  sclk_d, sdio_d, stb, sclk_w, sdio_w;
  int                    error_cnt, n_checks, k, n0;
  // wire levels from every driver's enable
  assign sclk_w = ser_out.sclk_oe ? ser_out.sclk_o : sclk_d;
  assign sdio_w = ser_out.sdio_oe ? ser_out.sdio_o : sdio_d;
  initial clk = 1'b0;
  always #10 clk = ~clk;
  ssh_core dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .port_b_line_two_i(sclk_w),
    .port_b_line_three_i(sdio_w), .ser_out(ser_out), .handshake_strobe_in(stb),
    .handshake_ack_out(ack), .parallel_port_a_i(pa_i), .parallel_port_a_o(pa_o), .irq_pending(irq_pending));
  ssh_peer peer (.clk(clk), .sclk_w(sclk_w), .sdio_w(sdio_w), .dut_out(ser_out.sdio_oe),
    .sclk_d(sclk_d), .sdio_d(sdio_d), .stb(stb));
  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one apb transfer, held until pready at an edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    r = prdata;
    chk("pready", 32'h1, {31'h0, pready});
    chk("pslverr", {31'h0, a > `SSH_OFF_SDR}, {31'h0, pslverr});
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // watchdog: far beyond the expected run
  initial begin
    #1000000;
    error_cnt++;
    stop_test();
  end
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000; pwdata = 32'h0;
    pa_i = 8'h00; seed = 8'h1A; error_cnt = 0; n_checks = 0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    // reset values and an unmapped place
    chk("ack_rst", 32'h1, {31'h0, ack});
    for (int a = 4; a <= 16; a += 4) begin
      apb(1'b0, a[11:0], 32'h0);
      chk("reg_rst", 32'h0, r);
    end
    apb(1'b0, 12'h03C, 32'h0);
    $display("test reset done");
    // internal clock, shifting out
    apb(1'b1, `SSH_OFF_ACR, 32'h50);
    for (int i = 0; i < 2; i++) begin
      seed = lfsr(seed);
      n0 = peer.n;
      apb(1'b1, `SSH_OFF_SDR, {24'h0, seed});
      for (k = 0; k < 100 && peer.n < n0 + 8; k++) @(posedge clk);
      chk("tx_byte", {24'h0, seed}, {24'h0, peer.rx});
      chk("tx_rate", 32'h2, peer.per);
      chk("tx_oe", 32'h3, {30'h0, ser_out.sclk_oe, ser_out.sdio_oe});
      apb(1'b0, `SSH_OFF_IFR, 32'h0);
      chk("no_flag_int", 32'h0, r);
    end
    $display("test internal out done");
    // external clock, shifting in
    apb(1'b1, `SSH_OFF_IER, 32'h20);
    apb(1'b1, `SSH_OFF_ACR, 32'h30);
    for (int i = 0; i < 2; i++) begin
      seed = lfsr(seed);
      b = seed;
      apb(1'b1, `SSH_OFF_SDR, 32'h0);
      chk("rx_oe", 32'h0, {30'h0, ser_out.sclk_oe, ser_out.sdio_oe});
      peer.send(b);
      for (k = 0; k < 20 && irq_pending !== 1'b1; k++) @(posedge clk);
      chk("irq", 32'h1, {31'h0, irq_pending});
      apb(1'b0, `SSH_OFF_IFR, 32'h0);
      chk("ifr_done", 32'hA0, r);
      apb(1'b0, `SSH_OFF_SDR, 32'h0);
      chk("rx_byte", {24'h0, b}, r);
      apb(1'b0, `SSH_OFF_IFR, 32'h0);
      chk("sdr_clears", 32'h0, r);
    end
    $display("test external in done");
    // handshake on port a
    apb(1'b1, `SSH_OFF_PCR, 32'h1);
    seed = lfsr(seed);
    apb(1'b1, `SSH_OFF_PORTA, {24'h0, seed});
    @(posedge clk);
    chk("pa_out", {24'h0, seed}, {24'h0, pa_o});
    chk("ack_wr", 32'h0, {31'h0, ack});
    peer.strobe();
    for (k = 0; k < 20 && ack !== 1'b1; k++) @(posedge clk);
    chk("ack_stb", 32'h1, {31'h0, ack});
    apb(1'b0, `SSH_OFF_IFR, 32'h0);
    chk("hs_flag", 32'h10, r);
    seed = lfsr(seed);
    pa_i <= seed;
    repeat (3) @(posedge clk);
    apb(1'b0, `SSH_OFF_PORTA, 32'h0);
    chk("pa_in", {24'h0, seed}, r);
    @(posedge clk);
    chk("ack_rd", 32'h0, {31'h0, ack});
    apb(1'b0, `SSH_OFF_IFR, 32'h0);
    chk("pa_clears", 32'h0, r);
    peer.strobe();
    for (k = 0; k < 20 && ack !== 1'b1; k++) @(posedge clk);
    apb(1'b1, `SSH_OFF_IFR, 32'h10);
    apb(1'b0, `SSH_OFF_IFR, 32'h0);
    chk("w1c", 32'h0, r);
    $display("test handshake done");
    stop_test();
  end
endmodule
`default_nettype wire

// file: verif/ssh_peer.sv
// behavioural far-side peripheral on the serial and handshake lines
`timescale 1ns/1ns
`default_nettype none
// ****************************************
// peer model
// ****************************************
module ssh_peer (
  input  wire logic clk,
  input  wire logic sclk_w,
  input  wire logic sdio_w,
  input  wire logic dut_out,
  output logic      sclk_d,
  output logic      sdio_d,
  output logic      stb
);
  logic [7:0] rx;   // bits captured from the block
  int         n;    // count of captured bits
  int         cc;   // free cycle count
  int         last; // cycle of previous clock rise
  int         per;  // cycles between the last two rises
  // idle levels: clock parked high, strobe high
  initial begin
    sclk_d = 1'b1;
    sdio_d = 1'b0;
    stb    = 1'b1;
    rx     = 8'h00;
    n      = 0;
    cc     = 0;
    last   = 0;
    per    = 0;
  end
  always @(posedge clk) cc <= cc + 1;
  // capture on the rising line edge, msb first
  always @(posedge sclk_w) begin
    if (dut_out) begin
      rx   <= {rx[6:0], sdio_w};
      n    <= n + 1;
      per  <= cc - last;
      last <= cc;
    end
  end
  // external clock of 8 cycles, data moves on the fall
  task automatic send(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      repeat (4) @(posedge clk);
      sclk_d <= 1'b0;
      sdio_d <= b[i];
      repeat (4) @(posedge clk);
      sclk_d <= 1'b1;
    end
    repeat (4) @(posedge clk);
    // stale data must not look valid once released
    sdio_d <= ~sdio_d;
  endtask
  // one low pulse on the strobe line
  task automatic strobe();
    repeat (2) @(posedge clk);
    stb <= 1'b0;
    repeat (4) @(posedge clk);
    stb <= 1'b1;
  endtask
endmodule
`default_nettype wire
